// File: src/arsc_ctrl.sv
`timescale 1ns/1ps
module arsc_ctrl
  import arsc_pkg::*;
#(
  parameter int CYCLES_PER_US = CLK_MHZ
)
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  // configuration words
  input  wire logic        CFG_WR,
  input  wire logic        CFG_ALT,
  input  wire logic [15:0] CFG_WDATA,
  output logic      [15:0] CFG_RDATA,
  // measurement commands
  input  wire logic        CMD_VALID,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic        CMD_ALT,
  input  wire logic [1:0]  THRESH_SEL,
  // status
  output logic             EOC,
  output logic             BUSY,
  output arsc_phase_type   PHASE,
  output logic             CFG_INVALID,
  // converter setup
  output logic             GAIN_X2,
  output logic             SHIFT_EN,
  output logic      [2:0]  SHIFT_AMOUNT,
  output logic      [4:0]  ADC_RES
);
  typedef struct packed {
    arsc_phase_type phase;
    logic           full;
    logic [15:0]    pri;
    logic [15:0]    alt;
    logic [15:0]    act;
    logic [15:0]    rdata;
    logic           eoc;
    logic           busy;
    logic           gain2;
    logic           shen;
    logic [2:0]     amt;
    logic [4:0]     res;
    logic           inval;
    logic [31:0]    pcnt;
  } arsc_ctrl_type;

  arsc_ctrl_type st;
  arsc_ctrl_type next_st;
  logic          tim_start;
  logic [31:0]   tim_load;
  logic          tim_done;

  // codes above six saturate at eighteen bits
  function automatic int res_index(input logic [15:0] cfg);
    int idx;
    idx = int'(cfg[RES_MSB:RES_LSB]);
    if (idx > RES_MAX - RES_MIN) begin
      idx = RES_MAX - RES_MIN;
    end
    return idx;
  endfunction : res_index

  function automatic logic [31:0] conv_cycles(input int idx);
    return 32'(CONV_TIME_US[idx] * CYCLES_PER_US);
  endfunction : conv_cycles

  localparam logic [31:0] TEMP_CYCLES = 32'(CONV_TIME_US[TEMP_RES - RES_MIN] * CYCLES_PER_US);
  localparam logic [31:0] CALC_CYCLES = 32'(CALC_TIME_US * CYCLES_PER_US);

  always_comb begin
    next_st   = st;
    tim_start = 1'b0;
    tim_load  = 32'h0;
    if (CFG_WR) begin
      if (CFG_ALT) begin
        next_st.alt = CFG_WDATA;
      end else begin
        next_st.pri = CFG_WDATA;
      end
    end
    next_st.rdata = CFG_ALT ? next_st.alt : next_st.pri;
    case (st.phase)
      PH_IDLE: begin
        next_st.act = next_st.pri;
        if (CMD_VALID && (CMD_CODE == CMD_MEASURE || CMD_CODE == CMD_SINGLE)) begin
          next_st.act   = CMD_ALT ? next_st.alt : next_st.pri;
          next_st.full  = (CMD_CODE == CMD_MEASURE);
          next_st.eoc   = 1'b0;
          next_st.busy  = 1'b1;
          next_st.phase = next_st.full ? PH_AZ_SENSOR : PH_SENSOR;
          tim_start     = 1'b1;
          tim_load      = conv_cycles(res_index(next_st.act));
        end
      end
      PH_AZ_SENSOR: begin
        if (tim_done) begin
          next_st.phase = PH_SENSOR;
          tim_start     = 1'b1;
          tim_load      = conv_cycles(res_index(st.act));
        end
      end
      PH_SENSOR: begin
        if (tim_done) begin
          tim_start = 1'b1;
          if (st.full) begin
            next_st.phase = PH_AZ_TEMP;
            tim_load      = TEMP_CYCLES;
          end else begin
            next_st.phase = PH_CALC;
            tim_load      = CALC_CYCLES;
          end
        end
      end
      PH_AZ_TEMP: begin
        if (tim_done) begin
          next_st.phase = PH_TEMP;
          tim_start     = 1'b1;
          tim_load      = TEMP_CYCLES;
        end
      end
      PH_TEMP: begin
        if (tim_done) begin
          next_st.phase = PH_CALC;
          tim_start     = 1'b1;
          tim_load      = CALC_CYCLES;
        end
      end
      PH_CALC: begin
        if (tim_done) begin
          next_st.phase = PH_IDLE;
          next_st.busy  = 1'b0;
          // other threshold modes drive the pin from outside logic
          next_st.eoc   = (THRESH_SEL == THRESH_NONE);
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
        next_st.busy  = 1'b0;
      end
    endcase
    next_st.shen  = next_st.act[SHIFT_EN_BIT];
    next_st.gain2 = next_st.act[SHIFT_EN_BIT];
    // code selects 0..43.25 % shift in the analog converter
    next_st.amt   = next_st.act[SHIFT_MSB:SHIFT_LSB];
    next_st.inval = !next_st.act[SHIFT_EN_BIT] && (next_st.amt != 3'h0);
    if (next_st.phase == PH_AZ_TEMP || next_st.phase == PH_TEMP) begin
      next_st.res = 5'(TEMP_RES);
    end else begin
      next_st.res = 5'(RES_MIN + res_index(next_st.act));
    end
    // cycles in this phase, read only by the checks below
    next_st.pcnt = (next_st.phase != st.phase) ? 32'h0 : st.pcnt + 32'h1;
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st       <= '0;
      st.phase <= PH_IDLE;
      st.pri   <= CFG_RESET;
      st.alt   <= CFG_RESET;
      st.act   <= CFG_RESET;
      st.rdata <= CFG_RESET;
      st.res   <= 5'(RES_MIN);
    end else begin
      st <= next_st;
    end
  end

  arsc_conv_timer u_timer (
    .clk   (MCLK),
    .rst_n (RSTN),
    .start (tim_start),
    .load  (tim_load),
    .done  (tim_done)
  );

  assign CFG_RDATA    = st.rdata;
  assign EOC          = st.eoc;
  assign BUSY         = st.busy;
  assign PHASE        = st.phase;
  assign CFG_INVALID  = st.inval;
  assign GAIN_X2      = st.gain2;
  assign SHIFT_EN     = st.shen;
  assign SHIFT_AMOUNT = st.amt;
  assign ADC_RES      = st.res;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  a_res_range: assert property (
    ADC_RES >= 5'(RES_MIN) && ADC_RES <= 5'(RES_MAX))
    else $error("converter resolution out of range");

  a_sensor_conv_len: assert property (
    (st.phase == PH_SENSOR && tim_done) |-> st.pcnt == conv_cycles(res_index(st.act)) - 32'h1)
    else $error("sensor conversion length wrong");

  a_shift_gate: assert property (
    SHIFT_EN == st.act[SHIFT_EN_BIT] && GAIN_X2 == SHIFT_EN)
    else $error("shift enable does not follow the word");

  a_shift_amount: assert property (
    CMD_VALID && (CMD_CODE == CMD_MEASURE || CMD_CODE == CMD_SINGLE) && st.phase == PH_IDLE
    && CMD_ALT && !CFG_WR |=> SHIFT_AMOUNT == $past(st.alt[SHIFT_MSB:SHIFT_LSB]))
    else $error("shift amount not taken from the selected word");

  a_gain_two: assert property (
    (st.phase != PH_IDLE && $stable(st.phase)) |-> $stable(GAIN_X2))
    else $error("converter gain changed during a measurement");

  a_invalid_flag: assert property (
    CFG_INVALID == (!SHIFT_EN && SHIFT_AMOUNT != 3'h0))
    else $error("invalid setup flag wrong");

  a_full_sequence: assert property (
    (st.phase == PH_SENSOR && st.full && tim_done) |=> st.phase == PH_AZ_TEMP ##1
    (st.phase == PH_AZ_TEMP)[*3])
    else $error("full measurement skipped temperature pair");

  a_eoc_start_low: assert property (
    (st.phase == PH_IDLE && CMD_VALID && CMD_CODE == CMD_MEASURE) |=> !EOC && BUSY)
    else $error("end of conversion not low at start");

  a_eoc_after_calc: assert property (
    $rose(EOC) |-> $past(st.phase) == PH_CALC && $past(THRESH_SEL) == THRESH_NONE)
    else $error("end of conversion before calculation");

  a_default_primary: assert property (
    (st.phase == PH_IDLE && !CMD_VALID && !CFG_WR) |=> st.act == $past(st.pri))
    else $error("idle setup not the primary word");
endmodule : arsc_ctrl

// File: common/arsc_pkg.sv
package arsc_pkg;
  // clock rate, 20 ns period
  localparam int CLK_MHZ = 50;

  // measurement commands
  localparam logic [7:0] CMD_MEASURE = 8'haa;
  localparam logic [7:0] CMD_SINGLE  = 8'ha8;

  // measurement configuration word fields
  localparam int SHIFT_EN_BIT = 15;
  localparam int SHIFT_MSB    = 14;
  localparam int SHIFT_LSB    = 12;
  localparam int RES_MSB      = 9;
  localparam int RES_LSB      = 7;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // resolutions in bits
  localparam int RES_MIN  = 12;
  localparam int RES_MAX  = 18;
  localparam int TEMP_RES = 16;

  // single conversion time per resolution, microseconds
  localparam int CONV_TIME_US [0:6] = '{140, 185, 250, 335, 470, 640, 890};
  // correction calculation time after the last conversion, microseconds
  localparam int CALC_TIME_US = 980;

  // threshold selection meaning plain end-of-conversion
  localparam logic [1:0] THRESH_NONE = 2'h0;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_AZ_SENSOR,
    PH_SENSOR,
    PH_AZ_TEMP,
    PH_TEMP,
    PH_CALC
  } arsc_phase_type;
endpackage : arsc_pkg

// File: src/arsc_conv_timer.sv
`timescale 1ns/1ps
module arsc_conv_timer
  import arsc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        start,
  input  wire logic [31:0] load,
  // one-cycle pulse, load cycles after start
  output logic             done
);
  typedef struct packed {
    logic        run;
    logic [31:0] cnt;
    logic        done;
  } arsc_timer_type;

  arsc_timer_type st;
  arsc_timer_type next_st;

  // load is at least two, so the subtraction never wraps
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.run = 1'b1;
      next_st.cnt = load - 32'h2;
    end else if (st.run) begin
      if (st.cnt == 32'h0) begin
        next_st.run  = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
endmodule : arsc_conv_timer

// File: verification/arsc_analog_model.sv
`timescale 1ns/1ps
module arsc_analog_model (
  // converter setup from the block
  input  wire logic        gain_x2,
  input  wire logic        shift_en,
  input  wire logic [2:0]  shift_amount,
  // what the converter input sees
  output logic      [1:0]  gain,
  output logic      [12:0] shift_bp
);
  // shift in hundredths of a percent of full scale
  localparam logic [12:0] SHIFT_TBL [0:7] = '{13'h0, 13'h2a3, 13'h4e2, 13'h785,
                                             13'h9c4, 13'hc67, 13'hf0a, 13'h10e5};

  always_comb begin
    gain     = gain_x2 ? 2'h2 : 2'h1;
    // a cleared enable means no shift, whatever the amount says
    shift_bp = shift_en ? SHIFT_TBL[shift_amount] : 13'h0;
  end
endmodule : arsc_analog_model

// File: verification/arsc_ctrl_tb.sv
`timescale 1ns/1ps
module arsc_ctrl_tb;
  import arsc_pkg::*;
  logic           MCLK, RSTN, CFG_WR, CFG_ALT, CMD_VALID, CMD_ALT;
  logic           EOC, BUSY, CFG_INVALID, GAIN_X2, SHIFT_EN;
  logic [15:0]    CFG_WDATA, CFG_RDATA;
  logic [7:0]     CMD_CODE;
  logic [1:0]     THRESH_SEL, gain;
  logic [2:0]     SHIFT_AMOUNT;
  logic [4:0]     ADC_RES;
  logic [12:0]    shift_bp;
  arsc_phase_type PHASE;
  int             fail_count = 0;
  int             n_tests = 0;
  int             cycles = 0;
  int             n;
  localparam logic [12:0] EXP_BP [0:7] = '{13'h0, 13'h2a3, 13'h4e2, 13'h785,
                                          13'h9c4, 13'hc67, 13'hf0a, 13'h10e5};

  // one cycle per microsecond keeps the long counts short
  arsc_ctrl #(.CYCLES_PER_US(1)) dut (.MCLK(MCLK), .RSTN(RSTN), .CFG_WR(CFG_WR),
    .CFG_ALT(CFG_ALT), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_ALT(CMD_ALT),
    .THRESH_SEL(THRESH_SEL), .EOC(EOC), .BUSY(BUSY), .PHASE(PHASE),
    .CFG_INVALID(CFG_INVALID), .GAIN_X2(GAIN_X2), .SHIFT_EN(SHIFT_EN),
    .SHIFT_AMOUNT(SHIFT_AMOUNT), .ADC_RES(ADC_RES));

  arsc_analog_model model (.gain_x2(GAIN_X2), .shift_en(SHIFT_EN),
    .shift_amount(SHIFT_AMOUNT), .gain(gain), .shift_bp(shift_bp));

  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // whole run is about 20000 cycles
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task step();
    @(posedge MCLK);
    #1;
  endtask : step

  task write_cfg(input logic alt, input logic [15:0] data);
    CFG_WR    = 1'b1;
    CFG_ALT   = alt;
    CFG_WDATA = data;
    step();
    CFG_WR = 1'b0;
    step();
  endtask : write_cfg

  // a stray command while busy must not change the length
  task run_cmd(input logic [7:0] code, input logic alt, input logic [1:0] thr,
               input int len, input logic eoc, input int res);
    CMD_VALID  = 1'b1;
    CMD_CODE   = code;
    CMD_ALT    = alt;
    THRESH_SEL = thr;
    step();
    CMD_VALID = 1'b0;
    check("busy", 1, BUSY);
    check("eoc start", 0, EOC);
    check("phase", code == CMD_MEASURE ? PH_AZ_SENSOR : PH_SENSOR, PHASE);
    check("res", res, ADC_RES);
    n = 0;
    while (BUSY === 1'b1 && n < 5000) begin
      step();
      n++;
      CMD_VALID = (n == 5);
    end
    check("length", len, n);
    check("eoc end", eoc, EOC);
    check("phase", PH_IDLE, PHASE);
    $display("test command %0h done", code);
  endtask : run_cmd

  initial begin
    {RSTN, CFG_WR, CFG_ALT, CMD_VALID, CMD_ALT} = 5'h0;
    CFG_WDATA  = 16'h0;
    CMD_CODE   = 8'h0;
    THRESH_SEL = 2'h0;
    repeat (8) @(posedge MCLK);
    #1 RSTN = 1'b1;
    step();
    check("eoc", 0, EOC);
    check("busy", 0, BUSY);
    check("res", RES_MIN, ADC_RES);
    check("rdata", CFG_RESET, CFG_RDATA);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      write_cfg(1'b0, 16'(i) << RES_LSB);
      check("rdata", 16'(i) << RES_LSB, CFG_RDATA);
      check("res", RES_MIN + i, ADC_RES);
    end
    for (int i = 0; i < 8; i++) begin
      write_cfg(1'b0, 16'h8000 | (16'(i) << SHIFT_LSB));
      check("gain", 2, gain);
      check("shift_en", 1, SHIFT_EN);
      check("amount", i, SHIFT_AMOUNT);
      check("shift", EXP_BP[i], shift_bp);
      check("invalid", 0, CFG_INVALID);
    end
    write_cfg(1'b0, 16'h3000);
    check("invalid", 1, CFG_INVALID);
    check("gain_x2", 0, GAIN_X2);
    check("shift_en", 0, SHIFT_EN);
    CMD_VALID = 1'b1;
    CMD_CODE  = 8'h55;
    step();
    CMD_VALID = 1'b0;
    step();
    check("busy", 0, BUSY);
    $display("test setup done");
    write_cfg(1'b0, 16'h0000);
    run_cmd(CMD_MEASURE, 1'b0, THRESH_NONE, 2200, 1'b1, 12);
    write_cfg(1'b0, 16'h0300);
    run_cmd(CMD_MEASURE, 1'b0, THRESH_NONE, 3700, 1'b1, 18);
    for (int i = 0; i < 7; i++) begin
      write_cfg(1'b0, 16'(i) << RES_LSB);
      run_cmd(CMD_SINGLE, 1'b0, THRESH_NONE, CONV_TIME_US[i] + CALC_TIME_US, 1'b1,
              RES_MIN + i);
    end
    write_cfg(1'b1, 16'hd300);
    check("rdata alt", 16'hd300, CFG_RDATA);
    write_cfg(1'b0, 16'h0000);
    run_cmd(CMD_SINGLE, 1'b1, THRESH_NONE, 1870, 1'b1, 18);
    run_cmd(CMD_SINGLE, 1'b0, 2'h1, 1120, 1'b0, 12);
    give_verdict();
  end
endmodule : arsc_ctrl_tb
